//--- inc/sec_clk_cfg.svh
// offsets, field positions, write mask and codes for the secondary clock block
`ifndef SEC_CLK_CFG_SVH
`define SEC_CLK_CFG_SVH
`define OFF_PM_CSR 8'h94
`define OFF_RSVD_LO 8'h98
`define OFF_RSVD_HI 8'h9C
`define OFF_SLOT_ID 8'hA0
`define OFF_CLK_CTRL 8'hA4
`define SLOT_CAP_ID 8'h04
`define SLOT_NEXT_PTR 8'hB0
`define CLK_STOP_CODE 2'h3
`define PM_STATE_D3 2'h3
`define PM_STATE_D0 2'h0
`define BIT_STOP_STATUS 13
`define BIT_CLKRUN_EN 14
`define BIT_CLKRUN_MODE 15
`define CTRL_RW_MASK 16'hC7FF
`endif

//--- inc/sec_clk_pkg.sv
// types shared by the secondary clock block
package sec_clk_pkg;
  // clock-stop sequencer states, gray along run -> stopping -> stopped
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOPPING = 2'b01,
    ST_STOPPED = 2'b11
  } stop_state_e;
endpackage

//--- rtl/clock_gate_low.sv
// glitch-free gate for one clock output, switching only while the clock is low
`timescale 1ns/100ps
module clock_gate_low (
  input wire logic clkIn,
  input wire logic rst,
  input wire logic runReq,
  output logic clkOut
);
  // enable latched on the falling edge so it changes only during the low phase
  logic enQ;

  always_ff @(negedge clkIn or posedge rst)
  begin
    if (rst)
    begin
      enQ <= 1'b1;
    end
    else
    begin
      enQ <= runReq;
    end
  end

  // and-gate: output high only while clock high and enable held
  assign clkOut = clkIn & enQ;
endmodule

//--- rtl/secondary_clock_and_slot_id.sv
// configuration registers for secondary clock gating, clock stop and slot ident
`timescale 1ns/100ps
`include "sec_clk_cfg.svh"
module secondary_clock_and_slot_id #(
  parameter int SlotOuts = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cfgWr,
  input wire logic cfgRd,
  input wire logic [7:0] cfgAddr,
  input wire logic [3:0] cfgByteEn,
  input wire logic [31:0] cfgWrData,
  output logic [31:0] cfgRdData,
  input wire logic forwardMode,
  input wire logic eepromSlotIdEn,
  input wire logic eepromLoadDone,
  input wire logic [1:0] powerState,
  input wire logic secBusIdle,
  input wire logic primaryReqPending,
  input wire logic secClkIn,
  output logic [SlotOuts-1:0] slotClockOut,
  output logic device1_clock_out,
  output logic device2_clock_out,
  output logic bridge_feedback_clock_out,
  output logic secClockStopped,
  output logic softResetPulse
);
  // every register of this module except the seven clock_gate_low enables, in one packed struct
  typedef struct packed {
    logic [15:0] clkCtrl;
    logic [4:0] slotNum;
    logic firstInChassis;
    logic [7:0] chassisNum;
    logic slotCapPresent;
    sec_clk_pkg::stop_state_e stopState;
    logic [1:0] prevPower;
    logic softReset;
    logic [31:0] rdData;
  } state_s;

  state_s stQ;
  state_s stD;

  // per-output run requests, [6:0] = feedback,dev2,dev1,slot3..slot0
  logic [6:0] runReq;
  logic [6:0] clkGated;
  logic stopWanted;
  logic [31:0] rdMux;
  logic [15:0] wrMask;

  // byte enables widened into a bit mask for the low half of the control word
  assign wrMask = {{8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}};

  // stop condition for the shared secondary clock
  always_comb
  begin
    stopWanted = 1'b0;
    if (stQ.clkCtrl[`BIT_CLKRUN_EN])
    begin
      if (stQ.clkCtrl[`BIT_CLKRUN_MODE])
      begin
        stopWanted = secBusIdle && !primaryReqPending;
      end
      else
      begin
        stopWanted = (powerState == `PM_STATE_D3);
      end
    end
  end

  // read mux; unmapped and reserved offsets read zero
  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (cfgAddr)
      `OFF_PM_CSR: rdMux = 32'h0000_0000;
      `OFF_SLOT_ID:
      begin
        if (stQ.slotCapPresent)
        begin
          rdMux = {stQ.chassisNum, 2'b00, stQ.firstInChassis, stQ.slotNum,
                   `SLOT_NEXT_PTR, `SLOT_CAP_ID};
        end
      end
      `OFF_CLK_CTRL:
      begin
        rdMux = {16'h0000, stQ.clkCtrl[15:14],
                 (stQ.stopState == sec_clk_pkg::ST_STOPPED), stQ.clkCtrl[12:0]};
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // next-state logic
  always_comb
  begin
    stD = stQ;
    stD.softReset = 1'b0;
    stD.prevPower = powerState;
    if (cfgRd)
    begin
      stD.rdData = rdMux;
    end
    if (eepromLoadDone)
    begin
      stD.slotCapPresent = eepromSlotIdEn;
    end
    if (cfgWr && cfgAddr == `OFF_SLOT_ID && stQ.slotCapPresent)
    begin
      if (cfgByteEn[2])
      begin
        stD.slotNum = cfgWrData[20:16];
        stD.firstInChassis = cfgWrData[21];
      end
      if (cfgByteEn[3])
      begin
        stD.chassisNum = cfgWrData[31:24];
      end
    end
    if (cfgWr && cfgAddr == `OFF_CLK_CTRL)
    begin
      stD.clkCtrl = (stQ.clkCtrl & ~(wrMask & `CTRL_RW_MASK)) |
                    (cfgWrData[15:0] & wrMask & `CTRL_RW_MASK);
    end
    // stop sequencer, one settle cycle before reporting stopped
    case (stQ.stopState)
      sec_clk_pkg::ST_RUN:
        if (stopWanted) stD.stopState = sec_clk_pkg::ST_STOPPING;
      sec_clk_pkg::ST_STOPPING:
        stD.stopState = stopWanted ? sec_clk_pkg::ST_STOPPED : sec_clk_pkg::ST_RUN;
      sec_clk_pkg::ST_STOPPED:
        if (!stopWanted) stD.stopState = sec_clk_pkg::ST_RUN;
      default: stD.stopState = sec_clk_pkg::ST_RUN;
    endcase
    if (stQ.prevPower == `PM_STATE_D3 && powerState == `PM_STATE_D0)
    begin
      stD.softReset = 1'b1;
      stD.clkCtrl = 16'h0000;
      stD.stopState = sec_clk_pkg::ST_RUN;
    end
  end

  // state register
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stQ <= '0;
    end
    else
    begin
      stQ <= stD;
    end
  end

  // run requests per output; reverse mode ignores the disable fields, only ST_STOPPED gates them
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_slot
      assign runReq[gi] = !(forwardMode && stQ.clkCtrl[2*gi+1 -: 2] == `CLK_STOP_CODE) &&
                          (stQ.stopState != sec_clk_pkg::ST_STOPPED);
    end
    for (gi = 4; gi < 7; gi++)
    begin : g_dev
      assign runReq[gi] = !(forwardMode && stQ.clkCtrl[gi+4]) &&
                          (stQ.stopState != sec_clk_pkg::ST_STOPPED);
    end
    for (gi = 0; gi < 7; gi++)
    begin : g_gate
      clock_gate_low u_gate (
        .clkIn(secClkIn),
        .rst(sys_rst),
        .runReq(runReq[gi]),
        .clkOut(clkGated[gi])
      );
    end
  endgenerate

  // output mapping
  assign slotClockOut = clkGated[SlotOuts-1:0];
  assign device1_clock_out = clkGated[4];
  assign device2_clock_out = clkGated[5];
  assign bridge_feedback_clock_out = clkGated[6];
  assign secClockStopped = (stQ.stopState == sec_clk_pkg::ST_STOPPED);
  assign softResetPulse = stQ.softReset;
  assign cfgRdData = stQ.rdData;

  mode0_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!stQ.clkCtrl[15] && powerState != 2'h3) |=> ##1 !secClockStopped)
    else $error("clock stopped outside D3hot in mode 0");
  idle_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    // a D3 to D0 soft reset in the last cycle legally restarts the clock
    (stQ.clkCtrl[15:14] == 2'b11 && secBusIdle && !primaryReqPending)[*3]
    ##0 !(stQ.prevPower == 2'h3 && powerState == 2'h0)
    |-> ##1 secClockStopped)
    else $error("idle bus did not stop clock");
  clkrun_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!stQ.clkCtrl[14])[*2] |-> !secClockStopped)
    else $error("clock stopped while protocol disabled");
  stop_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfgRd && cfgAddr == 8'hA4) |=> cfgRdData[13] == $past(secClockStopped))
    else $error("stop status bit mismatch");
  cap_id_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfgRd && cfgAddr == 8'hA0 && stQ.slotCapPresent) |=> cfgRdData[15:0] == 16'hB004)
    else $error("slot capability header wrong");
  cap_absent_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfgRd && cfgAddr == 8'hA0 && !stQ.slotCapPresent) |=> cfgRdData == 32'h0000_0000)
    else $error("absent capability visible");
  slot_rsvd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $past(cfgRd) |-> (cfgRdData[23:22] == 2'b00 || $past(cfgAddr) != 8'hA0))
    else $error("reserved slot bits nonzero");
  pm_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfgRd && cfgAddr == 8'h94) |=> cfgRdData[31:22] == 10'h000)
    else $error("bridge extension bits nonzero");
  rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cfgRd && (cfgAddr == 8'h98 || cfgAddr == 8'h9C)) |=> cfgRdData == 32'h0000_0000)
    else $error("reserved dword nonzero");
  soft_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ($past(powerState) == 2'h3 && powerState == 2'h0) |=> softResetPulse && stQ.clkCtrl == 16'h0)
    else $error("D3 to D0 soft reset missing");
endmodule

//--- testbench/sec_bus_model.sv
// far-side model: slots and devices watching every gated clock
`timescale 1ns/100ps
module sec_bus_model (
  input wire logic [6:0] clkOuts,
  input wire logic clrCounts,
  input wire logic busyReq,
  output logic secBusIdle,
  output logic [6:0] edgeSeen
);
  // bus is idle unless a test keeps it busy
  assign secBusIdle = !busyReq;
  // sticky flag per clock; any rising edge sets it, clrCounts clears it
  for (genvar i = 0; i < 7; i++)
  begin : g_mon
    always @(posedge clkOuts[i] or posedge clrCounts)
      edgeSeen[i] <= !clrCounts;
  end
endmodule

//--- testbench/secondary_clock_and_slot_id_tb.sv
// self-checking bench for the secondary clock and slot ident block
`timescale 1ns/100ps
`include "sec_clk_cfg.svh"
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module secondary_clock_and_slot_id_tb;
  logic sys_clk = 0;
  logic sys_rst = 1;
  logic cfgWr = 0;
  logic cfgRd = 0;
  logic [7:0] cfgAddr = 0;
  logic [3:0] cfgByteEn = 0;
  logic [31:0] cfgWrData = 0;
  logic [31:0] cfgRdData;
  logic forwardMode = 1;
  logic eepromSlotIdEn = 0;
  logic eepromLoadDone = 0;
  logic [1:0] powerState = 0;
  logic secBusIdle;
  logic primaryReqPending = 0;
  logic [3:0] slotClk;
  logic dev1Clk, dev2Clk, fbClk, secClockStopped, softResetPulse;
  logic clrCounts = 0;
  logic busyReq = 0;
  logic [6:0] edgeSeen;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int pulses = 0;
  // 100 MHz system clock; secondary source clock shares it
  always #5 sys_clk = ~sys_clk;
  secondary_clock_and_slot_id u_secondary_clock_and_slot_id (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .cfgWr(cfgWr), .cfgRd(cfgRd), .cfgAddr(cfgAddr),
    .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
    .forwardMode(forwardMode), .eepromSlotIdEn(eepromSlotIdEn),
    .eepromLoadDone(eepromLoadDone), .powerState(powerState), .secBusIdle(secBusIdle),
    .primaryReqPending(primaryReqPending), .secClkIn(sys_clk), .slotClockOut(slotClk),
    .device1_clock_out(dev1Clk), .device2_clock_out(dev2Clk),
    .bridge_feedback_clock_out(fbClk), .secClockStopped(secClockStopped),
    .softResetPulse(softResetPulse));
  sec_bus_model u_sec_bus_model (.clkOuts({fbClk, dev2Clk, dev1Clk, slotClk}),
    .clrCounts(clrCounts), .busyReq(busyReq), .secBusIdle(secBusIdle),
    .edgeSeen(edgeSeen));
  // cycle ceiling against hangs; pulse counter for soft reset
  always @(posedge sys_clk)
  begin
    cycles++;
    if (softResetPulse === 1'b1) pulses++;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge sys_clk);
    cfgAddr = a;
    cfgByteEn = be;
    cfgWrData = d;
    cfgWr = 1;
    @(negedge sys_clk);
    cfgWr = 0;
  endtask
  // read data is registered, so sample one full cycle after the strobe
  task automatic check_read(input logic [7:0] a, input logic [31:0] exp);
    @(negedge sys_clk);
    cfgAddr = a;
    cfgRd = 1;
    @(negedge sys_clk);
    cfgRd = 0;
    @(negedge sys_clk);
    `CHK(cfgRdData, exp)
  endtask
  // settle, clear edge flags, watch a window, then check the high phase
  task automatic check_clocks(input logic [6:0] exp, input logic stp);
    repeat (4) @(negedge sys_clk);
    clrCounts = 1;
    @(negedge sys_clk);
    clrCounts = 0;
    repeat (6) @(negedge sys_clk);
    `CHK(edgeSeen, exp)
    `CHK(secClockStopped, stp)
    @(posedge sys_clk);
    #1;
    `CHK({fbClk, dev2Clk, dev1Clk, slotClk}, exp)
    // return on a falling edge so callers drive inputs there
    @(negedge sys_clk);
  endtask
  task automatic test_reset();
    check_read(`OFF_CLK_CTRL, 32'h0000_0000);
    check_read(`OFF_SLOT_ID, 32'h0000_0000);
    check_read(`OFF_PM_CSR, 32'h0000_0000);
    check_read(`OFF_RSVD_LO, 32'h0000_0000);
    check_read(`OFF_RSVD_HI, 32'h0000_0000);
    check_clocks(7'h7f, 1'b0);
    $display("test reset done");
  endtask
  task automatic test_slot_ident();
    // write while hidden must be dropped
    cfg_write(`OFF_SLOT_ID, 4'hf, 32'hFFFF_FFFF);
    @(negedge sys_clk);
    eepromSlotIdEn = 1;
    eepromLoadDone = 1;
    @(negedge sys_clk);
    eepromLoadDone = 0;
    check_read(`OFF_SLOT_ID, 32'h0000_B004);
    cfg_write(`OFF_SLOT_ID, 4'hf, 32'hFFFF_FFFF);
    check_read(`OFF_SLOT_ID, 32'hFF3F_B004);
    cfg_write(`OFF_SLOT_ID, 4'h8, 32'h5A00_0000);
    check_read(`OFF_SLOT_ID, 32'h5A3F_B004);
    $display("test slot ident done");
  endtask
  // every two-bit code on all slots at once; code 11 also sets the single bits
  task automatic test_gates();
    // one output disabled at a time, so a swapped field shows up
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_0003);
    check_clocks(7'h7e, 1'b0);
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_000C);
    check_clocks(7'h7d, 1'b0);
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_0030);
    check_clocks(7'h7b, 1'b0);
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_00C0);
    check_clocks(7'h77, 1'b0);
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_0100);
    check_clocks(7'h6f, 1'b0);
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_0200);
    check_clocks(7'h5f, 1'b0);
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_0400);
    check_clocks(7'h3f, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      cfg_write(`OFF_CLK_CTRL, 4'h3, (c == 3) ? 32'h0000_07FF : {24'h0, {4{c[1:0]}}});
      check_clocks((c == 3) ? 7'h00 : 7'h7f, 1'b0);
    end
    @(negedge sys_clk);
    forwardMode = 0;
    check_clocks(7'h7f, 1'b0);
    forwardMode = 1;
    cfg_write(`OFF_CLK_CTRL, 4'hf, 32'hFFFF_7FFF);
    check_read(`OFF_CLK_CTRL, 32'h0000_47FF);
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_4000);
    check_clocks(7'h7f, 1'b0);
    $display("test gates done");
  endtask
  task automatic test_auto_stop();
    @(negedge sys_clk);
    powerState = `PM_STATE_D3;
    check_clocks(7'h00, 1'b1);
    check_read(`OFF_CLK_CTRL, 32'h0000_6000);
    powerState = `PM_STATE_D0;
    check_clocks(7'h7f, 1'b0);
    `CHK(pulses, 1)
    check_read(`OFF_CLK_CTRL, 32'h0000_0000);
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_C000);
    check_clocks(7'h00, 1'b1);
    primaryReqPending = 1;
    check_clocks(7'h7f, 1'b0);
    primaryReqPending = 0;
    busyReq = 1;
    check_clocks(7'h7f, 1'b0);
    busyReq = 0;
    cfg_write(`OFF_CLK_CTRL, 4'h3, 32'h0000_8000);
    check_clocks(7'h7f, 1'b0);
    $display("test auto stop done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge sys_clk);
    sys_rst = 0;
    test_reset();
    test_slot_ident();
    test_gates();
    test_auto_stop();
    tally_and_finish();
  end
endmodule
